// [hdl/alu_bits.sv]
// Bit-test, conditional-subtract and bit-reversed index unit with its own repeat sequencer.
// Assumes operands come from same-clock register-file logic; start is taken only while ready.
//
// Contract
// - Bit test ANDs operands, writes no destination, only updates flags.
// - Bit-reversed mode adds index to pointer with carries running downward.
// - Subtract step: non-negative difference replaces dividend, shifted left, LSB one.
// - Subtract step: negative difference keeps dividend, shifted left, zero inserted.
// - After i-j+1 steps: quotient in low i-j+1 bits, remainder above.
// - Repeat count N executes the operation N+1 times.
// - No interrupts during single-instruction repeat; allowed during block repeat.
`timescale 1ns/1ps
module alu_bits
    import alu_bits_pkg::*;
#(
    parameter int CNT_W = CNT_W_DEF
)(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              start,
    input  wire op_t               op,
    input  wire logic              block_mode,
    input  wire logic [CNT_W-1:0]  repeat_n,
    input  wire logic [DATA_W-1:0] operand_a,
    input  wire logic [DATA_W-1:0] operand_b,
    output logic                   ready,
    output logic                   step_valid,
    output logic                   done,
    output logic [DATA_W-1:0]      result,
    output logic                   flag_zero,
    output logic                   flag_negative,
    output logic                   irq_allowed
);
    typedef struct packed {
        seq_state_t        st;
        op_t               op;
        logic              block;
        logic [CNT_W-1:0]  cnt;
        logic [DATA_W-1:0] acc;
        logic [DATA_W-1:0] opb;
        logic [DATA_W-1:0] result;
        logic              step;
        logic              done;
        logic              fz;
        logic              fn;
        logic              irq_ok;
        logic              ready;
    } alu_state_t;

    localparam alu_state_t STATE_RST = '{
        st: ST_IDLE, op: OP_PASS, block: 1'h0, cnt: '0, acc: WORD_ZERO, opb: WORD_ZERO,
        result: WORD_ZERO, step: 1'h0, done: 1'h0, fz: FLAG_RST, fn: FLAG_RST,
        irq_ok: IRQ_OK_RST, ready: 1'h1};

    // Counts wider than the data word are never loaded by software, so they are refused
    if (CNT_W < 1 || CNT_W > DATA_W) begin : g_cnt_w_check
        $error("alu_bits: CNT_W must lie between 1 and the data width");
    end

    alu_state_t        r;
    alu_state_t        r_nxt;
    logic [DATA_W:0]   diff;
    logic [DATA_W-1:0] and_val;

    rev_add_if rev_bus ();
    rev_carry_adder u_rev (
        .port_a (rev_bus)
    );

    assign rev_bus.base  = r.acc;
    assign rev_bus.index = r.opb;
    // Extra top bit makes the borrow the sign of the unshifted difference
    assign diff    = {1'b0, r.acc} - {1'b0, r.opb};
    assign and_val = r.acc & r.opb;

    always_comb begin
        r_nxt      = r;
        r_nxt.step = 1'b0;
        r_nxt.done = 1'b0;
        case (r.st)
            ST_IDLE: begin
                if (start) begin
                    r_nxt.st    = ST_RUN;
                    r_nxt.op    = op;
                    r_nxt.block = block_mode;
                    r_nxt.cnt   = repeat_n;
                    r_nxt.acc   = operand_a;
                    r_nxt.opb   = operand_b;
                end
            end
            ST_RUN: begin
                r_nxt.step = 1'b1;
                case (r.op)
                    OP_FLAG_ONLY_AND_TEST: begin
                        // Only flags move; accumulator and result stay put
                        r_nxt.fz = (and_val == WORD_ZERO);
                        r_nxt.fn = and_val[SIGN_POS];
                    end
                    OP_CONDITIONAL_SUBTRACT: begin
                        if (!diff[DATA_W]) begin
                            r_nxt.acc = {diff[DATA_W-2:0], 1'b1};
                        end else begin
                            r_nxt.acc = {r.acc[DATA_W-2:0], 1'b0};
                        end
                        // Quotient bits accumulate from bit 0 upward, remainder above
                        r_nxt.result = r_nxt.acc;
                    end
                    OP_BIT_REVERSED_INDEX: begin
                        r_nxt.acc    = rev_bus.sum;
                        r_nxt.result = rev_bus.sum;
                    end
                    default: begin
                        r_nxt.result = r.acc;
                    end
                endcase
                // Count N gives N+1 passes; count reaches zero on the last one
                if (r.cnt == '0) begin
                    r_nxt.st   = ST_IDLE;
                    r_nxt.done = 1'b1;
                end else begin
                    r_nxt.cnt = r.cnt - CNT_W'(1);
                end
            end
            default: begin
                r_nxt = STATE_RST;
            end
        endcase
        // Single repeat holds the buses, so interrupts wait until it ends
        r_nxt.irq_ok = !(r_nxt.st == ST_RUN && !r_nxt.block);
        r_nxt.ready  = (r_nxt.st == ST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= STATE_RST;
        end else begin
            r <= r_nxt;
        end
    end

    assign ready         = r.ready;
    assign step_valid    = r.step;
    assign done          = r.done;
    assign result        = r.result;
    assign flag_zero     = r.fz;
    assign flag_negative = r.fn;
    assign irq_allowed   = r.irq_ok;

    // Checking helpers: independent reverse-carry model and a step tally
    function automatic logic [DATA_W-1:0] bitrev(input logic [DATA_W-1:0] v);
        logic [DATA_W-1:0] o;
        o = '0;
        for (int k = 0; k < DATA_W; k++) begin
            o[k] = v[DATA_W-1-k];
        end
        return o;
    endfunction

    logic [DATA_W-1:0] rev_model;
    logic [CNT_W:0]    steps_seen;
    logic [CNT_W:0]    n_lat;

    assign rev_model = bitrev(bitrev(r.acc) + bitrev(r.opb));

    always_ff @(posedge clk) begin
        if (!resetn) begin
            steps_seen <= '0;
            n_lat      <= '0;
        end else if (r.st == ST_IDLE && start) begin
            steps_seen <= '0;
            n_lat      <= {1'b0, repeat_n};
        end else if (r.step) begin
            steps_seen <= steps_seen + 1'b1;
        end
    end

    wire run_tst = (r.st == ST_RUN) && (r.op == OP_FLAG_ONLY_AND_TEST);
    wire run_sub = (r.st == ST_RUN) && (r.op == OP_CONDITIONAL_SUBTRACT);
    wire run_rev = (r.st == ST_RUN) && (r.op == OP_BIT_REVERSED_INDEX);

    property p_test_keeps_result;
        @(posedge clk) disable iff (!resetn) run_tst |=> $stable(result);
    endproperty
    a_test_keeps_result: assert property (p_test_keeps_result)
        else $error("bit test changed the result word");

    property p_test_flags;
        @(posedge clk) disable iff (!resetn)
            run_tst |=> (flag_zero == ($past(and_val) == WORD_ZERO))
                     && (flag_negative == $past(and_val[SIGN_POS]));
    endproperty
    a_test_flags: assert property (p_test_flags)
        else $error("bit test flags do not match the AND of the operands");

    property p_rev_sum;
        @(posedge clk) disable iff (!resetn) run_rev |=> result == $past(rev_model);
    endproperty
    a_rev_sum: assert property (p_rev_sum)
        else $error("bit-reversed index sum is wrong");

    property p_rev_carry_drop;
        @(posedge clk) disable iff (!resetn)
            run_rev && r.acc == 32'h0000_0001 && r.opb == 32'h0000_0001 |=> result == WORD_ZERO;
    endproperty
    a_rev_carry_drop: assert property (p_rev_carry_drop)
        else $error("carry out of bit zero was not discarded");

    property p_sub_take;
        @(posedge clk) disable iff (!resetn)
            run_sub && !diff[DATA_W] |=> result == {$past(diff[DATA_W-2:0]), 1'b1};
    endproperty
    a_sub_take: assert property (p_sub_take)
        else $error("non-negative subtract step did not keep the shifted difference");

    property p_sub_keep;
        @(posedge clk) disable iff (!resetn)
            run_sub && diff[DATA_W] |=> result == {$past(r.acc[DATA_W-2:0]), 1'b0};
    endproperty
    a_sub_keep: assert property (p_sub_keep)
        else $error("negative subtract step did not just shift the dividend");

    property p_sub_sign;
        @(posedge clk) disable iff (!resetn)
            run_sub |=> result[0] == !$past(diff[DATA_W]);
    endproperty
    a_sub_sign: assert property (p_sub_sign)
        else $error("quotient bit disagrees with the sign of the difference");

    property p_pass_count;
        @(posedge clk) disable iff (!resetn) done |-> steps_seen == n_lat;
    endproperty
    a_pass_count: assert property (p_pass_count)
        else $error("repeat count N did not give N+1 passes");

    property p_single_masks_irq;
        @(posedge clk) disable iff (!resetn)
            (r.st == ST_RUN) |-> (irq_allowed == r.block) && !ready;
    endproperty
    a_single_masks_irq: assert property (p_single_masks_irq)
        else $error("interrupt permission wrong during a repeat");

    property p_done_frees;
        @(posedge clk) disable iff (!resetn) done |-> ready && irq_allowed;
    endproperty
    a_done_frees: assert property (p_done_frees)
        else $error("unit not released after the last pass");

    c_test_run:  cover property (@(posedge clk) disable iff (!resetn) run_tst ##1 done);
    c_sub_four:  cover property (@(posedge clk) disable iff (!resetn)
                                 run_sub [*4] ##1 done);
    c_rev_block: cover property (@(posedge clk) disable iff (!resetn)
                                 run_rev && r.block ##1 step_valid);
endmodule

// [hdl/alu_bits_pkg.sv]
// Shared constants and types for the bit-test / conditional-subtract / bit-reversed ALU.
// Assumes a 32-bit datapath and one 200 MHz clock with a synchronous active-low reset.
package alu_bits_pkg;
    localparam int DATA_W      = 32;
    localparam int CNT_W_DEF   = 32;
    localparam int SIGN_POS    = DATA_W - 1;
    localparam int CLK_MHZ     = 200;

    typedef enum logic [1:0] {
        OP_FLAG_ONLY_AND_TEST     = 2'h0,
        OP_CONDITIONAL_SUBTRACT   = 2'h1,
        OP_BIT_REVERSED_INDEX     = 2'h2,
        OP_PASS                   = 2'h3
    } op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'h0,
        ST_RUN  = 1'h1
    } seq_state_t;

    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
    localparam logic              FLAG_RST  = 1'h0;
    localparam logic              IRQ_OK_RST = 1'h1;
endpackage

// [hdl/rev_add_if.sv]
// Carries the operands and sum between the sequencer and the reverse-carry adder.
// Purely combinational; no clocking.
`timescale 1ns/1ps
interface rev_add_if;
    import alu_bits_pkg::*;
    logic [DATA_W-1:0] base;
    logic [DATA_W-1:0] index;
    logic [DATA_W-1:0] sum;
    modport user  (output base, output index, input sum);
    modport adder (input base, input index, output sum);
endinterface

// [hdl/rev_carry_adder.sv]
// Adder whose carries ripple from each bit to the next lower bit.
// Assumes operands held stable by the caller; result is combinational.
`timescale 1ns/1ps
module rev_carry_adder
    import alu_bits_pkg::*;
(
    rev_add_if.adder port_a
);
    logic [DATA_W:0] carry;

    always_comb begin
        carry         = '0;
        port_a.sum    = '0;
        // Carry enters at the top and walks downward; carry out of bit 0 is dropped
        for (int b = DATA_W - 1; b >= 0; b--) begin
            port_a.sum[b] = port_a.base[b] ^ port_a.index[b] ^ carry[b+1];
            carry[b]      = (port_a.base[b] & port_a.index[b])
                          | (carry[b+1] & (port_a.base[b] ^ port_a.index[b]));
        end
    end
endmodule

// [tb/test_alu_bits.sv]
// Self-checking bench for the bit-test, conditional-subtract and bit-reversed unit.
// Assumes a pass every cycle, the first one at the rising edge after the take.
`timescale 1ns/1ps
module test_alu_bits
    import alu_bits_pkg::*;
;
    logic                 clk;
    logic                 resetn;
    logic                 start;
    op_t                  op;
    logic                 block_mode;
    logic [CNT_W_DEF-1:0] repeat_n;
    logic [DATA_W-1:0]    operand_a;
    logic [DATA_W-1:0]    operand_b;
    logic                 ready;
    logic                 step_valid;
    logic                 done;
    logic [DATA_W-1:0]    result;
    logic                 flag_zero;
    logic                 flag_negative;
    logic                 irq_allowed;
    int                   err_count;
    int                   checks_done;
    int                   cycles = 0;
    logic [31:0]          seed;
    logic [DATA_W-1:0]    exp_res;
    logic                 exp_z;
    logic                 exp_n;

    alu_bits u_dut (.clk(clk), .resetn(resetn), .start(start), .op(op),
        .block_mode(block_mode), .repeat_n(repeat_n), .operand_a(operand_a),
        .operand_b(operand_b), .ready(ready), .step_valid(step_valid), .done(done),
        .result(result), .flag_zero(flag_zero), .flag_negative(flag_negative),
        .irq_allowed(irq_allowed));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Carries travel from each bit down to the next lower one
    function automatic logic [31:0] rev_add(input logic [31:0] x, input logic [31:0] y);
        logic [31:0] s;
        logic        c;
        c = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            s[i] = x[i] ^ y[i] ^ c;
            c = (x[i] & y[i]) | (c & (x[i] ^ y[i]));
        end
        return s;
    endfunction

    function automatic logic [31:0] step(input op_t o, input logic [31:0] r,
                                         input logic [31:0] a, input logic [31:0] b);
        logic [32:0] d;
        d = {1'b0, r} - {1'b0, b};
        case (o)
            OP_CONDITIONAL_SUBTRACT: return d[32] ? {r[30:0], 1'b0} : {d[30:0], 1'b1};
            OP_BIT_REVERSED_INDEX:   return rev_add(r, b);
            OP_PASS:                 return a;
            default:                 return r;
        endcase
    endfunction

    task automatic chk1(input string what, input logic e, input logic s);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic chk32(input string what, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Called at a falling edge with ready high; returns at the falling clock edge while done is high
    task automatic run(input op_t o, input logic blk, input int n, input logic [31:0] a,
                       input logic [31:0] b, input logic refuse);
        logic [31:0] cur;
        logic        rf;
        rf = refuse && (n > 0);
        cur = (o == OP_FLAG_ONLY_AND_TEST) ? exp_res : a;
        start <= 1'b1;
        op <= o;
        block_mode <= blk;
        repeat_n <= 32'(n);
        operand_a <= a;
        operand_b <= b;
        @(negedge clk);
        // A start while busy must not disturb the running operation
        start <= rf;
        op <= OP_PASS;
        operand_a <= ~a;
        chk1("ready", 1'b0, ready);
        chk1("irq_allowed", blk, irq_allowed);
        for (int k = 0; k <= n; k++) begin
            @(negedge clk);
            // A single pass already holds start low, and the next call raises it here
            if (k == 0 && n > 0) start <= 1'b0;
            cur = step(o, cur, a, b);
            if (o == OP_FLAG_ONLY_AND_TEST) begin
                exp_z = ((a & b) == WORD_ZERO);
                exp_n = a[SIGN_POS] & b[SIGN_POS];
            end
            chk1("step_valid", 1'b1, step_valid);
            chk1("done", k == n, done);
            chk1("ready", k == n, ready);
            chk1("irq_allowed", (k == n) | blk, irq_allowed);
            chk32("result", cur, result);
            chk1("flag_zero", exp_z, flag_zero);
            chk1("flag_negative", exp_n, flag_negative);
        end
        exp_res = cur;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        logic [31:0] x;
        logic [31:0] y;
        int          n;
        op_t         o;
        seed = 32'h0000_002B;
        err_count = 0;
        checks_done = 0;
        exp_res = WORD_ZERO;
        exp_z = FLAG_RST;
        exp_n = FLAG_RST;
        resetn = 1'b0;
        start = 1'b0;
        op = OP_PASS;
        block_mode = 1'b0;
        repeat_n = '0;
        operand_a = WORD_ZERO;
        operand_b = WORD_ZERO;
        repeat (2) @(negedge clk);
        chk1("ready", 1'b1, ready);
        chk32("result", WORD_ZERO, result);
        chk1("irq_allowed", IRQ_OK_RST, irq_allowed);
        chk1("step_valid", 1'b0, step_valid);
        chk1("done", 1'b0, done);
        chk1("flag_zero", FLAG_RST, flag_zero);
        chk1("flag_negative", FLAG_RST, flag_negative);
        resetn <= 1'b1;
        run(OP_CONDITIONAL_SUBTRACT, 1'b0, 3, 32'h21, 32'h28, 1'b1);
        chk32("walk", 32'h0000_0036, result);
        run(OP_FLAG_ONLY_AND_TEST, 1'b1, 0, 32'hF000_0000, 32'h8000_0001, 1'b0);
        run(OP_FLAG_ONLY_AND_TEST, 1'b0, 2, 32'h0F0F_0F0F, 32'hF0F0_F0F0, 1'b1);
        run(OP_BIT_REVERSED_INDEX, 1'b1, 7, WORD_ZERO, 32'h0000_0100, 1'b0);
        run(OP_BIT_REVERSED_INDEX, 1'b0, 7, WORD_ZERO, 32'h0000_0200, 1'b1);
        run(OP_BIT_REVERSED_INDEX, 1'b0, 0, 32'h0000_0001, 32'h0000_0001, 1'b0);
        for (int t = 0; t < 60; t++) begin
            o = op_t'(2'(rnd()));
            x = rnd();
            y = rnd();
            if (o == OP_CONDITIONAL_SUBTRACT) begin
                x[31] = 1'b0;
                y[31] = 1'b0;
            end
            n = int'(rnd() % 8);
            run(o, x[3], n, x, y, y[5]);
        end
        // Positive aligned divisions of random sizes, quotient and remainder both checked
        for (int t = 0; t < 30; t++) begin
            x = (rnd() >> (1 + rnd() % 31)) | 32'h0000_0001;
            y = x >> (rnd() % $clog2(64'(x) + 1));
            y = y ^ (rnd() & (y >> 1));
            n = $clog2(64'(x) + 1) - $clog2(64'(y) + 1);
            run(OP_CONDITIONAL_SUBTRACT, y[0], n, x, y << n, x[1]);
            chk32("quotient", x / y, result & ((32'h1 << (n + 1)) - 1));
            chk32("remainder", x % y, result >> (n + 1));
        end
        final_report();
    end
endmodule
